// >>> design/unique_word_symbol_framer.sv
// Transmit symbol framer: sync words, pilots, ramps, register slave
//
// Overview of operation
// - Modulation type may change at any symbol
// - Code units end where modulation region ends (the framer closes a payload unit only on pay_last, not on a mode change)
// - Several users share one region's coding unit
// - MAC header has fixed known block size
// - MAC header coded as its own unit
// - Empty payload filled with dummies, never stops
// - Sync words sent every interval regardless
// - Pilots are cyclic continuation of sync word
// - Pilot count ranges zero up to N
// - Continuous pilot count fixed while running
// - Bursts open and close with R-symbol ramps
// - Ramp-up feeds zero symbols, then burst
// - Short ramp-up: downstream window of length R
// - Ramp-down zeros follow final burst symbol
// - Short ramp-down: downstream window of length R
// - Sync word is U stored uncoded symbols
// - Burst middle alternates payload and sync words
// - All burst blocks length N except last
// - Last burst block has its own length
// - Burst lengths reconfigurable for each burst
// - Sync word length zero is supported
// - Header indication follows sync every I intervals
// - Groups ordered most robust first after header
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module unique_word_symbol_framer
  import framer_pkg::*;
#(
  parameter int SYM_W = SYM_WIDTH,
  parameter int LEN_W = LEN_WIDTH,
  parameter int SW_DEPTH = SW_DEPTH_DEF,
  parameter int SYM_DIV = SYM_DIV_DEF
)
(
  input logic core_clk,
  input logic rst_n,
  input logic [AVS_AW-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic [SYM_W-1:0] pay_data,
  input logic pay_valid,
  input logic pay_sof,
  input logic pay_last,
  input logic [MOD_W-1:0] pay_mod,
  output logic pay_ack,
  output logic [SYM_W-1:0] sym_data,
  output logic sym_valid,
  output logic [2:0] sym_kind,
  output logic [MOD_W-1:0] sym_mod,
  output logic sym_fec_end,
  output logic sym_ramp,
  output logic [LEN_W-1:0] sym_ramp_pos
);
  localparam int IW = $clog2(SW_DEPTH);
  localparam logic [7:0] DIV_LAST = 8'(SYM_DIV - 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] div;
    logic run;
    logic burst;
    logic win;
    logic go;
    logic [LEN_W-1:0] u;
    logic [LEN_W-1:0] nlen;
    logic [LEN_W-1:0] nend;
    logic [LEN_W-1:0] p;
    logic [LEN_W-1:0] rlen;
    logic [LEN_W-1:0] blocks;
    logic [LEN_W-1:0] fh;
    logic [LEN_W-1:0] fi;
    logic [LEN_W-1:0] hl;
    logic [LEN_W-1:0] lu;
    logic [LEN_W-1:0] ln;
    logic [LEN_W-1:0] lnend;
    logic [LEN_W-1:0] lp;
    logic [LEN_W-1:0] lr;
    logic [LEN_W-1:0] lblocks;
    logic [LEN_W-1:0] lh;
    logic [LEN_W-1:0] li;
    logic [LEN_W-1:0] lhl;
    logic lwin;
    logic lburst;
    fr_state_t st;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] widx;
    logic [LEN_W-1:0] blk;
    logic [LEN_W-1:0] ivl;
    logic [LEN_W-1:0] hcnt;
    logic final_s;
    logic in_hdr;
    logic [MOD_W-1:0] last_mod;
    logic order_err;
    logic [IW-1:0] sw_idx;
    logic waitreq;
    logic [31:0] rdata;
    logic [SYM_W-1:0] sym_data;
    logic sym_valid;
    logic [2:0] sym_kind;
    logic [MOD_W-1:0] sym_mod;
    logic sym_fec_end;
    logic sym_ramp;
    logic [LEN_W-1:0] sym_ramp_pos;
    logic pay_ack;
  } state_t;

  state_t r;
  state_t next_r;
  logic sym_en;
  logic last_blk;
  logic is_fhi;
  logic [LEN_W-1:0] ext_cur;
  logic [LEN_W-1:0] blk_len;
  logic [LEN_W-1:0] pay_len;
  logic [SYM_W-1:0] mem_rd;
  logic mem_we;

  // Symbol-rate enable from the clock divider
  assign sym_en = (r.div == '0);
  assign last_blk = r.lburst && (r.blk == r.lblocks - 1'b1);
  assign is_fhi = !r.lburst && (r.ivl == '0) && (r.lh != '0);
  assign ext_cur = is_fhi ? r.lh : r.lp;
  assign blk_len = last_blk ? r.lnend : r.ln;
  // Pilots sit inside the N-symbol interval, so payload shrinks by them
  assign pay_len = (blk_len > ext_cur) ? blk_len - ext_cur : '0;
  assign mem_we = avs_write && !r.waitreq && (avs_address == OFS_SW_DATA);

  sync_word_mem #(
    .W(SYM_W),
    .DEPTH(SW_DEPTH)
  ) u_sync_mem (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(mem_we),
    .wr_addr(r.sw_idx),
    .wr_data(avs_writedata[SYM_W-1:0]),
    .rd_addr(r.widx[IW-1:0]),
    .rd_data(mem_rd)
  );

  // State that follows a finished sync word (zero-length parts skipped)
  function automatic fr_state_t after_sync(input state_t x, input logic fin,
    input logic [LEN_W-1:0] iv, input logic [LEN_W-1:0] bk);
    logic [LEN_W-1:0] e;
    logic [LEN_W-1:0] bl;
    e = (!x.lburst && iv == '0 && x.lh != '0) ? x.lh : x.lp;
    bl = (x.lburst && bk == x.lblocks - 1'b1) ? x.lnend : x.ln;
    if (fin)
      after_sync = (x.lr != '0) ? ST_RAMP_DN : ST_IDLE;
    else if (e != '0)
      after_sync = ST_EXT;
    else if (bl != '0)
      after_sync = ST_PAY;
    else
      after_sync = ST_SYNC;
  endfunction : after_sync

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    logic blk_done;
    logic hdr_now;
    logic oset;
    logic [LEN_W-1:0] hc;
    logic [31:0] rd_mux;
    blk_done = 1'b0;
    oset = 1'b0;
    hdr_now = r.in_hdr | pay_sof;
    hc = pay_sof ? '0 : r.hcnt;
    rd_mux = '0;
    next_r = r;
    next_r.div = sym_en ? DIV_LAST : r.div - 1'b1;
    next_r.pay_ack = 1'b0;
    if (sym_en)
    begin
      next_r.sym_valid = 1'b1;
      next_r.sym_data = '0;
      next_r.sym_kind = KIND_ZERO;
      next_r.sym_fec_end = 1'b0;
      next_r.sym_ramp = 1'b0;
      next_r.sym_ramp_pos = r.cnt;
      next_r.cnt = r.cnt + 1'b1;
      next_r.widx = (r.widx == r.lu - 1'b1) ? '0 : r.widx + 1'b1;
      case (r.st)
        ST_IDLE:
        begin
          next_r.sym_valid = 1'b0;
          next_r.cnt = '0;
          if ((r.run && !r.burst) || (r.burst && r.go))
          begin
            // Lengths frozen here; register writes later wait for next start
            next_r.lu = r.u;
            next_r.ln = r.nlen;
            next_r.lnend = r.nend;
            next_r.lp = r.p;
            next_r.lr = r.rlen;
            next_r.lblocks = r.blocks;
            next_r.lh = r.fh;
            next_r.li = r.fi;
            next_r.lhl = r.hl;
            next_r.lwin = r.win;
            next_r.lburst = r.burst;
            next_r.go = 1'b0;
            next_r.blk = '0;
            next_r.ivl = '0;
            next_r.final_s = 1'b0;
            next_r.in_hdr = 1'b0;
            next_r.last_mod = '0;
            next_r.st = ST_START;
          end
        end
        ST_START:
        begin
          next_r.sym_valid = 1'b0;
          next_r.cnt = '0;
          next_r.widx = '0;
          if (r.lburst && r.lr != '0)
            next_r.st = ST_RAMP_UP;
          else
            next_r.st = (r.lu != '0) ? ST_SYNC : after_sync(r, 1'b0, r.ivl, r.blk);
        end
        ST_RAMP_UP:
        begin
          // Zero symbols fill the filter; window gate drives shaping downstream
          next_r.sym_ramp = r.lwin;
          if (r.cnt == r.lr - 1'b1)
          begin
            next_r.cnt = '0;
            next_r.widx = '0;
            next_r.st = (r.lu != '0) ? ST_SYNC : after_sync(r, 1'b0, r.ivl, r.blk);
          end
        end
        ST_SYNC:
        begin
          next_r.sym_data = mem_rd;
          next_r.sym_kind = KIND_SYNC;
          if (r.cnt == r.lu - 1'b1)
          begin
            next_r.cnt = '0;
            next_r.widx = '0;
            next_r.st = after_sync(r, r.final_s, r.ivl, r.blk);
          end
        end
        ST_EXT:
        begin
          next_r.sym_data = (r.lu != '0) ? mem_rd : '0;
          next_r.sym_kind = is_fhi ? KIND_FHI : KIND_PILOT;
          if (r.cnt == ext_cur - 1'b1)
          begin
            next_r.cnt = '0;
            if (pay_len != '0)
              next_r.st = ST_PAY;
            else
              blk_done = 1'b1;
          end
        end
        ST_PAY:
        begin
          if (pay_valid)
          begin
            // Mode changes pass through on any symbol
            next_r.sym_data = pay_data;
            next_r.sym_mod = pay_mod;
            next_r.pay_ack = 1'b1;
            if (hdr_now)
            begin
              next_r.sym_kind = KIND_HDR;
              next_r.hcnt = hc + 1'b1;
              next_r.sym_fec_end = (hc == r.lhl - 1'b1);
              next_r.in_hdr = (hc != r.lhl - 1'b1);
              next_r.last_mod = '0;
            end
            else
            begin
              next_r.sym_kind = KIND_PAY;
              // Mixed users share the unit; only region end closes it
              next_r.sym_fec_end = pay_last;
              if (pay_mod < r.last_mod)
                oset = 1'b1;
              next_r.last_mod = pay_mod;
            end
          end
          else
          begin
            next_r.sym_kind = KIND_DUMMY;
          end
          if (r.cnt == pay_len - 1'b1)
            blk_done = 1'b1;
        end
        ST_RAMP_DN:
        begin
          next_r.sym_ramp = r.lwin;
          if (r.cnt == r.lr - 1'b1)
          begin
            next_r.cnt = '0;
            next_r.st = ST_IDLE;
          end
        end
        default:
        begin
          next_r.st = ST_IDLE;
        end
      endcase
      if (blk_done)
      begin
        next_r.cnt = '0;
        next_r.widx = '0;
        if (r.lburst)
        begin
          next_r.final_s = last_blk;
          next_r.blk = last_blk ? r.blk : r.blk + 1'b1;
        end
        else
        begin
          next_r.ivl = (r.ivl >= r.li - 1'b1) ? '0 : r.ivl + 1'b1;
        end
        // With no sync word the next block or ramp follows at once
        next_r.st = (r.lu != '0) ? ST_SYNC :
          after_sync(r, last_blk, next_r.ivl, next_r.blk);
        if (!r.lburst && !r.run)
          next_r.st = ST_IDLE;
      end
    end
    if (oset)
      next_r.order_err = 1'b1;

    // ****************************************
    // Register slave: one wait cycle per access
    // ****************************************
    next_r.waitreq = !((avs_read || avs_write) && r.waitreq);
    case (avs_address)
      OFS_CTRL:
        rd_mux[CTRL_WIN:CTRL_RUN] = {r.win, r.burst, r.run};
      OFS_SYNC_LEN:
        rd_mux[LEN_W-1:0] = r.u;
      OFS_PAY_LEN:
        rd_mux[LEN_W-1:0] = r.nlen;
      OFS_END_LEN:
        rd_mux[LEN_W-1:0] = r.nend;
      OFS_PILOT:
        rd_mux[LEN_W-1:0] = r.p;
      OFS_RAMP:
        rd_mux[LEN_W-1:0] = r.rlen;
      OFS_BLOCKS:
        rd_mux[LEN_W-1:0] = r.blocks;
      OFS_FHI_LEN:
        rd_mux[LEN_W-1:0] = r.fh;
      OFS_FHI_IVL:
        rd_mux[LEN_W-1:0] = r.fi;
      OFS_HDR_LEN:
        rd_mux[LEN_W-1:0] = r.hl;
      OFS_STATUS:
      begin
        rd_mux[STAT_BUSY] = (r.st != ST_IDLE);
        rd_mux[STAT_ORDER] = r.order_err;
        rd_mux[STAT_STATE_LSB +: 3] = r.st;
      end
      OFS_SW_IDX:
        rd_mux[IW-1:0] = r.sw_idx;
      default:
        rd_mux = '0;
    endcase
    if (avs_read && r.waitreq)
      next_r.rdata = rd_mux;
    if (avs_write && !r.waitreq)
    begin
      case (avs_address)
        OFS_CTRL:
        begin
          next_r.run = avs_writedata[CTRL_RUN];
          next_r.burst = avs_writedata[CTRL_BURST];
          next_r.win = avs_writedata[CTRL_WIN];
          if (avs_writedata[CTRL_GO])
            next_r.go = 1'b1;
        end
        OFS_SYNC_LEN:
          next_r.u = avs_writedata[LEN_W-1:0];
        OFS_PAY_LEN:
          next_r.nlen = avs_writedata[LEN_W-1:0];
        OFS_END_LEN:
          next_r.nend = avs_writedata[LEN_W-1:0];
        OFS_PILOT:
          next_r.p = avs_writedata[LEN_W-1:0];
        OFS_RAMP:
          next_r.rlen = avs_writedata[LEN_W-1:0];
        OFS_BLOCKS:
          next_r.blocks = avs_writedata[LEN_W-1:0];
        OFS_FHI_LEN:
          next_r.fh = avs_writedata[LEN_W-1:0];
        OFS_FHI_IVL:
          next_r.fi = avs_writedata[LEN_W-1:0];
        OFS_HDR_LEN:
          next_r.hl = avs_writedata[LEN_W-1:0];
        OFS_STATUS:
          // A new order fault in the same cycle outlives the clear
          if (avs_writedata[STAT_ORDER] && !oset)
            next_r.order_err = 1'b0;
        OFS_SW_IDX:
          next_r.sw_idx = avs_writedata[IW-1:0];
        OFS_SW_DATA:
          next_r.sw_idx = r.sw_idx + 1'b1;
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.waitreq <= 1'b1;
      r.u <= LEN_W'(RST_SYNC_LEN);
      r.nlen <= LEN_W'(RST_PAY_LEN);
      r.nend <= LEN_W'(RST_END_LEN);
      r.p <= LEN_W'(RST_PILOT);
      r.rlen <= LEN_W'(RST_RAMP);
      r.blocks <= LEN_W'(RST_BLOCKS);
      r.fh <= LEN_W'(RST_FHI_LEN);
      r.fi <= LEN_W'(RST_FHI_IVL);
      r.hl <= LEN_W'(RST_HDR_LEN);
    end
    else
      r <= next_r;
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq;
  assign pay_ack = r.pay_ack;
  assign sym_data = r.sym_data;
  assign sym_valid = r.sym_valid;
  assign sym_kind = r.sym_kind;
  assign sym_mod = r.sym_mod;
  assign sym_fec_end = r.sym_fec_end;
  assign sym_ramp = r.sym_ramp;
  assign sym_ramp_pos = r.sym_ramp_pos;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sync_opens_a: assert property (
    (sym_en && r.st == ST_RAMP_UP && r.cnt == r.lr - 1'b1 && r.lu != '0)
    |=> r.st == ST_SYNC)
    else $error("burst body does not open with sync word");
  ramp_len_a: assert property (
    (r.st == ST_RAMP_UP || r.st == ST_RAMP_DN) |-> r.cnt < r.lr)
    else $error("ramp longer than configured");
  ramp_down_a: assert property (
    (sym_en && r.st == ST_SYNC && r.final_s && r.cnt == r.lu - 1'b1 && r.lr != '0)
    |=> r.st == ST_RAMP_DN ##1 (r.sym_kind == KIND_SYNC))
    else $error("ramp-down does not follow closing sync word");
  sync_always_a: assert property (
    (sym_en && r.st == ST_PAY && r.cnt == pay_len - 1'b1 && r.lu != '0 && r.run
     && !r.lburst) |=> r.st == ST_SYNC)
    else $error("sync word skipped after payload");
  dummy_fill_a: assert property (
    (sym_en && r.st == ST_PAY && !pay_valid)
    |=> (r.sym_valid && r.sym_kind == KIND_DUMMY && !r.pay_ack))
    else $error("empty payload slot not filled");
  params_held_a: assert property (
    (r.st != ST_IDLE && $past(r.st) != ST_IDLE)
    |-> ($stable(r.lu) && $stable(r.ln) && $stable(r.lp) && $stable(r.lr)
         && $stable(r.lnend)))
    else $error("latched lengths changed mid-transmission");
  pilot_wrap_a: assert property (
    (r.st == ST_EXT && r.lu != '0) |-> r.widx < r.lu)
    else $error("pilot index left the sync word");
  hdr_unit_a: assert property (
    (sym_en && r.st == ST_PAY && pay_valid && r.in_hdr && !pay_sof
     && r.hcnt == r.lhl - 1'b1)
    |=> (r.sym_fec_end && r.sym_kind == KIND_HDR && !r.in_hdr))
    else $error("header unit not closed at fixed length");
  last_short_a: assert property (
    (sym_en && r.st == ST_PAY && last_blk && r.cnt == r.lnend - r.lp - 1'b1)
    |=> r.st != ST_PAY)
    else $error("final block not using its own length");
endmodule : unique_word_symbol_framer

// >>> design/framer_pkg.sv
// Shared constants, register map and state encoding of the symbol framer
package framer_pkg;
  // ****************************************
  // Widths and rates
  // ****************************************
  localparam int SYM_WIDTH = 8;
  localparam int LEN_WIDTH = 16;
  localparam int MOD_W = 4;
  localparam int SW_DEPTH_DEF = 64;
  localparam int SYM_DIV_DEF = 4;
  localparam int AVS_AW = 6;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_SYNC_LEN = 6'h04;
  localparam logic [5:0] OFS_PAY_LEN = 6'h08;
  localparam logic [5:0] OFS_END_LEN = 6'h0C;
  localparam logic [5:0] OFS_PILOT = 6'h10;
  localparam logic [5:0] OFS_RAMP = 6'h14;
  localparam logic [5:0] OFS_BLOCKS = 6'h18;
  localparam logic [5:0] OFS_FHI_LEN = 6'h1C;
  localparam logic [5:0] OFS_FHI_IVL = 6'h20;
  localparam logic [5:0] OFS_HDR_LEN = 6'h24;
  localparam logic [5:0] OFS_STATUS = 6'h28;
  localparam logic [5:0] OFS_SW_IDX = 6'h2C;
  localparam logic [5:0] OFS_SW_DATA = 6'h30;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_BURST = 1;
  localparam int CTRL_WIN = 2;
  localparam int CTRL_GO = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ORDER = 1;
  localparam int STAT_STATE_LSB = 4;
  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [15:0] RST_SYNC_LEN = 16'h0010;
  localparam logic [15:0] RST_PAY_LEN = 16'h0030;
  localparam logic [15:0] RST_END_LEN = 16'h0030;
  localparam logic [15:0] RST_PILOT = 16'h0000;
  localparam logic [15:0] RST_RAMP = 16'h0004;
  localparam logic [15:0] RST_BLOCKS = 16'h0001;
  localparam logic [15:0] RST_FHI_LEN = 16'h0000;
  localparam logic [15:0] RST_FHI_IVL = 16'h0001;
  localparam logic [15:0] RST_HDR_LEN = 16'h0010;
  // ****************************************
  // Symbol kinds and states
  // ****************************************
  localparam logic [2:0] KIND_ZERO = 3'h0;
  localparam logic [2:0] KIND_SYNC = 3'h1;
  localparam logic [2:0] KIND_PILOT = 3'h2;
  localparam logic [2:0] KIND_FHI = 3'h3;
  localparam logic [2:0] KIND_PAY = 3'h4;
  localparam logic [2:0] KIND_DUMMY = 3'h5;
  localparam logic [2:0] KIND_HDR = 3'h6;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RAMP_UP, ST_SYNC, ST_EXT, ST_PAY, ST_RAMP_DN
  } fr_state_t;
endpackage : framer_pkg

// >>> design/sync_word_mem.sv
// Sync word symbol store with registered read port
`timescale 1ns/100ps
module sync_word_mem
#(
  parameter int W = 8,
  parameter int DEPTH = 64
)
(
  input logic core_clk,
  input logic rst_n,
  input logic wr_en,
  input logic [$clog2(DEPTH)-1:0] wr_addr,
  input logic [W-1:0] wr_data,
  input logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } mem_state_t;

  mem_state_t r;
  mem_state_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.rd = r.mem[rd_addr];
    if (wr_en)
      next_r.mem[wr_addr] = wr_data;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign rd_data = r.rd;
endmodule : sync_word_mem

// >>> dv/mac_source.sv
// Upstream payload source model that feeds symbols to the framer
`timescale 1ns/100ps
module mac_source
  import framer_pkg::*;
(
  input wire logic core_clk,
  input wire logic pay_ack,
  output logic [SYM_WIDTH-1:0] pay_data,
  output logic pay_valid,
  output logic pay_sof,
  output logic pay_last,
  output logic [MOD_W-1:0] pay_mod
);
  // Entry: header start flag, modulation type, symbol
  logic [12:0] pq[$];
  logic [SYM_WIDTH-1:0] last_sent = 8'h00;
  initial
  begin
    pay_valid = 1'b0;
    pay_last = 1'b0;
    pay_sof = 1'b0;
    pay_mod = 4'h0;
    pay_data = 8'hFF;
  end
  // ****************************************
  // Symbol hand-off
  // ****************************************
  // Idle data is the inverse of the last symbol so a stale value never matches
  always @(posedge core_clk)
  begin
    if (pay_ack === 1'b1 && pq.size() > 0)
    begin
      last_sent = pq[0][SYM_WIDTH-1:0];
      void'(pq.pop_front());
    end
    pay_valid <= (pq.size() > 0);
    pay_data <= (pq.size() > 0) ? pq[0][SYM_WIDTH-1:0] : ~last_sent;
    pay_sof <= (pq.size() > 0) && pq[0][12];
    pay_mod <= (pq.size() > 0) ? pq[0][11:8] : 4'h0;
    pay_last <= (pq.size() == 1);
  end
endmodule : mac_source

// >>> dv/tb.sv
// Self-checking bench for the symbol framer
`timescale 1ns/100ps
module tb
  import framer_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AVS_AW-1:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, pay_valid, pay_sof, pay_last, pay_ack;
  logic sym_valid, sym_fec_end, sym_ramp;
  logic [SYM_WIDTH-1:0] pay_data, sym_data;
  logic [MOD_W-1:0] pay_mod, sym_mod;
  logic [2:0] sym_kind;
  logic [LEN_WIDTH-1:0] sym_ramp_pos;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  logic [SYM_WIDTH-1:0] sw[2];
  logic [5:0] ofs[5] = '{OFS_SYNC_LEN, OFS_PAY_LEN, OFS_RAMP, OFS_PILOT, 6'h3C};
  logic [31:0] rv[5] = '{{16'h0, RST_SYNC_LEN}, {16'h0, RST_PAY_LEN}, {16'h0, RST_RAMP},
    {16'h0, RST_PILOT}, 32'h0};
  int fail_count = 0;
  int num_checks = 0;
  int ph = 0;
  always #10 core_clk = ~core_clk;
  unique_word_symbol_framer unique_word_symbol_framer_i (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pay_data(pay_data), .pay_valid(pay_valid),
    .pay_sof(pay_sof), .pay_last(pay_last), .pay_mod(pay_mod), .pay_ack(pay_ack),
    .sym_data(sym_data), .sym_valid(sym_valid), .sym_kind(sym_kind), .sym_mod(sym_mod),
    .sym_fec_end(sym_fec_end), .sym_ramp(sym_ramp), .sym_ramp_pos(sym_ramp_pos));
  mac_source mac_source_i (.core_clk(core_clk), .pay_ack(pay_ack), .pay_data(pay_data),
    .pay_valid(pay_valid), .pay_sof(pay_sof), .pay_last(pay_last), .pay_mod(pay_mod));
  // ****************************************
  // Shared tasks
  // ****************************************
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check("bus answer", n < 50, 1);
  endtask : bus
  // Modulation field doubles as ramp position for zero symbols
  task note(input logic [2:0] k, input logic [7:0] v, input logic c, input logic f = 1'b0,
    input logic [3:0] m = 4'h0, input logic rp = 1'b0);
    exp_q.push_back({rp, m, f, c, k, v});
  endtask : note
  task sync(input int u);
    for (int j = 0; j < u; j++)
      note(KIND_SYNC, sw[j % 2], 1'b1);
  endtask : sync
  task drain(input string nm);
    int n;
    n = 0;
    while ((exp_q.size() != 0 || sym_valid !== 1'b0) && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    check("queue empty", exp_q.size(), 0);
    $display("test %s done", nm);
  endtask : drain
  task burst(input int u, input int n, input int ne, input int r, input int b, input logic w,
    input logic h);
    logic [7:0] v;
    logic [3:0] m;
    int t;
    m = 4'h0;
    t = 0;
    bus(1'b1, OFS_SYNC_LEN, u);
    bus(1'b1, OFS_PAY_LEN, n);
    bus(1'b1, OFS_END_LEN, ne);
    bus(1'b1, OFS_RAMP, r);
    bus(1'b1, OFS_BLOCKS, b);
    bus(1'b1, OFS_HDR_LEN, 2);
    for (int j = 0; j < r; j++)
      note(KIND_ZERO, 8'h00, 1'b1, 1'b0, 4'(j), w);
    sync(u);
    for (int i = 0; i < b; i++)
    begin
      repeat ((i == b - 1) ? ne : n)
      begin
        v = 8'($urandom);
        // Header at mode 0; then non-decreasing modes, or falling ones to trip the order flag
        m = (h && t < 2) ? 4'h0 : h ? m + 4'($urandom % 2) : 4'hF - 4'(t);
        mac_source_i.pq.push_back({h && t == 0, m, v});
        note((h && t < 2) ? KIND_HDR : KIND_PAY, v, 1'b1,
          (h && t == 1) || t == n * (b - 1) + ne - 1, m);
        t++;
      end
      sync(u);
    end
    for (int j = 0; j < r; j++)
      note(KIND_ZERO, 8'h00, 1'b1, 1'b0, 4'(j), w);
    bus(1'b1, OFS_CTRL, w ? 32'h0000000E : 32'h0000000A);
    // Let the start latch the lengths before the register moves
    repeat (2 * SYM_DIV_DEF) @(posedge core_clk);
    bus(1'b1, OFS_PAY_LEN, n + 3);
    drain("burst");
    bus(1'b0, OFS_STATUS, 32'h0);
    check("order flag", rd[STAT_ORDER], !h);
    bus(1'b1, OFS_STATUS, 32'h00000002);
  endtask : burst
  // ****************************************
  // Output watcher
  // ****************************************
  always @(posedge core_clk)
  begin
    if (sym_valid !== 1'b1)
      ph <= 0;
    else
    begin
      if (ph == 0)
      begin
        if (exp_q.size() == 0)
          check("unexpected symbol", 1, 0);
        else
        begin
          e = exp_q.pop_front();
          check("sym kind", sym_kind, e[10:8]);
          check("fec end", sym_fec_end, e[12]);
          check("ramp gate", sym_ramp, e[17]);
          if (e[11])
            check("sym data", sym_data, e[7:0]);
          if (e[10:8] == KIND_PAY || e[10:8] == KIND_HDR)
            check("sym mod", sym_mod, e[16:13]);
          else if (e[10:8] == KIND_ZERO)
            check("ramp pos", sym_ramp_pos, e[16:13]);
        end
      end
      ph <= (ph == SYM_DIV_DEF - 1) ? 0 : ph + 1;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int n;
    void'($urandom(32'hE2F9));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ofs[i])
    begin
      bus(1'b0, ofs[i], 32'h0);
      check("reg reset", rd, rv[i]);
    end
    bus(1'b1, OFS_SW_IDX, 32'h0);
    for (int j = 0; j < 2; j++)
    begin
      sw[j] = 8'($urandom);
      bus(1'b1, OFS_SW_DATA, {24'h0, sw[j]});
    end
    bus(1'b0, OFS_SW_DATA, 32'h0);
    check("word store read", rd, 32'h0);
    $display("test registers done");
    burst(2, 6, 3, 2, 2, 1'b0, 1'b1);
    burst(0, 4, 1, 1, 2, 1'b1, 1'b0);
    bus(1'b1, OFS_SYNC_LEN, 2);
    bus(1'b1, OFS_PAY_LEN, 5);
    bus(1'b1, OFS_PILOT, 3);
    bus(1'b1, OFS_FHI_LEN, 4);
    bus(1'b1, OFS_FHI_IVL, 2);
    // Indication every second interval, pilots in the others
    for (int k = 0; k < 3; k++)
    begin
      sync(2);
      for (int j = 0; j < ((k % 2 == 0) ? 4 : 3); j++)
        note((k % 2 == 0) ? KIND_FHI : KIND_PILOT, sw[j % 2], 1'b1);
      repeat ((k % 2 == 0) ? 1 : 2) note(KIND_DUMMY, 8'h00, 1'b0);
    end
    bus(1'b1, OFS_CTRL, 32'h00000001);
    repeat (2 * SYM_DIV_DEF) @(posedge core_clk);
    bus(1'b1, OFS_PILOT, 1);
    n = 0;
    while (exp_q.size() > 4 && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    bus(1'b1, OFS_CTRL, 32'h0);
    drain("continuous");
    bus(1'b0, OFS_STATUS, 32'h0);
    check("order clear", rd[STAT_ORDER], 1'b0);
    complete_run();
  end
  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule : tb
